/* File: verilog/fsp_pkg.sv */
// Shared constants and types for the flash self-programming command and address sequencer.
package fsp_pkg;

   // Register addresses on the CPU peripheral bus.
   localparam logic [15:0] FSP_ADDR_STATUS = 16'hFFA1;
   localparam logic [15:0] FSP_ADDR_CMD = 16'hFFA3;
   localparam logic [15:0] FSP_ADDR_PTR_LO = 16'hFFA4;
   localparam logic [15:0] FSP_ADDR_PTR_HI = 16'hFFA5;
   localparam logic [15:0] FSP_ADDR_CMP_HI = 16'hFFA6;
   localparam logic [15:0] FSP_ADDR_CMP_LO = 16'hFFA7;
   localparam logic [15:0] FSP_ADDR_WBUF = 16'hFFA8;

   // Values after reset.
   localparam logic [7:0] FSP_RST_BYTE = 8'h00;
   localparam logic [2:0] FSP_RST_CMD = 3'h0;

   // Status register field positions.
   localparam int FSP_VERIFY_BIT = 1;
   localparam int FSP_PROTECT_BIT = 2;

   // Command codes.
   localparam logic [2:0] FSP_CMD_NONE = 3'h0;
   localparam logic [2:0] FSP_CMD_VERIFY_BLOCK = 3'h1;
   localparam logic [2:0] FSP_CMD_VERIFY_MULTI = 3'h2;
   localparam logic [2:0] FSP_CMD_ERASE = 3'h3;
   localparam logic [2:0] FSP_CMD_BLANK = 3'h4;
   localparam logic [2:0] FSP_CMD_BYTE_WRITE = 3'h5;

   // Erased data pattern, last block offset and pointer step.
   localparam logic [7:0] FSP_ERASED_BYTE = 8'hFF;
   localparam logic [7:0] FSP_LAST_OFFSET = 8'hFF;
   localparam logic [11:0] FSP_PTR_STEP = 12'h001;

   typedef enum logic [5:0] {
      ST_IDLE = 6'b00_0001,
      ST_READ = 6'b00_0010,
      ST_CHECK = 6'b00_0100,
      ST_PROG = 6'b00_1000,
      ST_ERASE = 6'b01_0000,
      ST_WAIT = 6'b10_0000
   } fsp_state_t;

endpackage

/* File: verilog/fsp_err_flag.sv */
// Sticky error flag: hardware sets it, software clears it by writing zero.
module fsp_err_flag
   import fsp_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic set_i,
   input wire logic clr_i,
   output logic flag_o
);

   typedef struct packed {
      logic flag;
   } fsp_flag_state_t;

   fsp_flag_state_t cur_ff;
   fsp_flag_state_t nxt_state;

   // A failure reported in the same cycle as the clearing write must not be lost.
   always_comb begin
      nxt_state = cur_ff;
      if (set_i) begin
         nxt_state.flag = 1'b1;
      end else if (clr_i) begin
         nxt_state.flag = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_state;
      end
   end

   assign flag_o = cur_ff.flag;

   a_set_wins_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i) set_i |=> flag_o)
      else $error("error flag not set after a set request");
   a_clear_works: assert property (@(posedge clk_i) disable iff (!rst_n_i) clr_i && !set_i |=> !flag_o)
      else $error("error flag not cleared by a zero write");

endmodule

/* File: verilog/fsp_addr_ctr.sv */
// Address pointer counter and its compare registers.
module fsp_addr_ctr
   import fsp_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_ptr_lo_i,
   input wire logic wr_ptr_hi_i,
   input wire logic wr_cmp_lo_i,
   input wire logic wr_cmp_hi_i,
   input wire logic inc_i,
   output logic [7:0] ptr_lo_o,
   output logic [7:0] ptr_hi_o,
   output logic [7:0] cmp_lo_o,
   output logic [7:0] cmp_hi_o,
   output logic match_o
);

   typedef struct packed {
      logic [7:0] ptr_lo;
      logic [7:0] ptr_hi;
      logic [7:0] cmp_lo;
      logic [7:0] cmp_hi;
   } fsp_ctr_state_t;

   fsp_ctr_state_t cur_ff;
   fsp_ctr_state_t nxt_state;
   logic [11:0] sum;

   // The upper nibbles take part in the match so that stray bits never yield a false end.
   assign match_o = ({cur_ff.ptr_hi, cur_ff.ptr_lo} == {cur_ff.cmp_hi, cur_ff.cmp_lo});
   assign sum = {cur_ff.ptr_hi[3:0], cur_ff.ptr_lo} + FSP_PTR_STEP;

   always_comb begin
      nxt_state = cur_ff;
      if (wr_ptr_lo_i) begin
         nxt_state.ptr_lo = wdata_i;
      end
      if (wr_ptr_hi_i) begin
         nxt_state.ptr_hi = wdata_i;
      end
      if (wr_cmp_lo_i) begin
         nxt_state.cmp_lo = wdata_i;
      end
      if (wr_cmp_hi_i) begin
         nxt_state.cmp_hi = wdata_i;
      end
      if (inc_i && !match_o) begin
         nxt_state.ptr_lo = sum[7:0];
         nxt_state.ptr_hi = {cur_ff.ptr_hi[7:4], sum[11:8]};
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cur_ff <= {FSP_RST_BYTE, FSP_RST_BYTE, FSP_RST_BYTE, FSP_RST_BYTE};
      end else begin
         cur_ff <= nxt_state;
      end
   end

   assign ptr_lo_o = cur_ff.ptr_lo;
   assign ptr_hi_o = cur_ff.ptr_hi;
   assign cmp_lo_o = cur_ff.cmp_lo;
   assign cmp_hi_o = cur_ff.cmp_hi;

   a_cmp_reset_zero: assert property (@(posedge clk_i) $rose(rst_n_i)
      |-> cmp_lo_o == 8'h00 && cmp_hi_o == 8'h00)
      else $error("compare registers not cleared by reset");
   a_hold_at_match: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      match_o && !wr_ptr_lo_i && !wr_ptr_hi_i |=> ptr_lo_o == $past(ptr_lo_o))
      else $error("pointer moved past the compare value");

endmodule

/* File: verilog/fsp_seq_top.sv */
// Command decode, error reporting and address walk of the flash self-programming sequencer.
// Operation
// - Multi-address verify flags verify or protect errors.
// - Block erase works in on-board and self modes.
// - Blank check tests every block location erased; the code checks only pointer through compare.
// - Byte write programs one byte at pointer.
// - Writing one over zero sets protect error.
// - Undefined codes end at once, may flag errors.
// - Pointer registers give start address of operations.
// - Pointer counts up until equal to compare.
// - Compare registers bound the verify walk.
// - Reset clears both compare registers.
// - Whole-block verify flags verify or protect errors.
// - Byte write data comes from write buffer.
// - Verify error flag sets on failure, zero clears.
module fsp_seq_top
   import fsp_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic [15:0] cpu_addr_i,
   input wire logic [7:0] cpu_wdata_i,
   input wire logic cpu_wr_i,
   input wire logic cpu_rd_i,
   output logic [7:0] cpu_rdata_o,
   input wire logic self_prog_mode_i,
   input wire logic onboard_mode_i,
   input wire logic block_protect_i,
   output logic seq_busy_o,
   output logic [11:0] fl_addr_o,
   output logic fl_rd_o,
   input wire logic [7:0] fl_rdata_i,
   input wire logic fl_rd_fail_i,
   output logic fl_wr_o,
   output logic [7:0] fl_wdata_o,
   output logic fl_erase_o,
   input wire logic fl_ack_i,
   input wire logic fl_fail_i
);

   typedef struct packed {
      fsp_state_t st;
      logic [2:0] cmd;
      logic [7:0] wbuf;
      logic [7:0] rdata;
      logic rd;
      logic wr;
      logic erase;
      logic busy;
   } fsp_top_state_t;

   fsp_top_state_t cur_ff;
   fsp_top_state_t nxt_state;
   logic [1:0] rst_sync_ff;
   logic rst_n;

   logic idle;
   logic wr_cmd;
   logic wr_status;
   logic code_valid;
   logic mode_ok;
   logic launch;
   logic set_verify;
   logic set_protect;
   logic inc;
   logic last;
   logic fail;
   logic one_over_zero;
   logic verify_flag;
   logic protect_flag;
   logic match;
   logic [7:0] ptr_lo;
   logic [7:0] ptr_hi;
   logic [7:0] cmp_lo;
   logic [7:0] cmp_hi;
   logic [7:0] rd_mux;

   // Reset is asserted at once but released only after two clean edges.
   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_ff[1];

   assign idle = (cur_ff.st == ST_IDLE);
   assign wr_cmd = cpu_wr_i && (cpu_addr_i == FSP_ADDR_CMD);
   assign wr_status = cpu_wr_i && (cpu_addr_i == FSP_ADDR_STATUS);
   assign code_valid = (cpu_wdata_i[2:0] >= FSP_CMD_VERIFY_BLOCK) && (cpu_wdata_i[2:0] <= FSP_CMD_BYTE_WRITE);
   // Erase alone is also open to on-board programming; the rest need self mode.
   assign mode_ok = self_prog_mode_i || (onboard_mode_i && cpu_wdata_i[2:0] == FSP_CMD_ERASE);
   assign launch = wr_cmd && idle && code_valid && mode_ok && !block_protect_i;
   assign one_over_zero = |(~fl_rdata_i & cur_ff.wbuf);

   always_comb begin
      unique case (cur_ff.cmd)
         FSP_CMD_BLANK: fail = (fl_rdata_i != FSP_ERASED_BYTE);
         FSP_CMD_BYTE_WRITE: fail = 1'b0;
         default: fail = fl_rd_fail_i;
      endcase
      if (cur_ff.cmd == FSP_CMD_VERIFY_BLOCK) begin
         last = (ptr_lo == FSP_LAST_OFFSET) || match;
      end else begin
         last = match;
      end
   end

   always_comb begin
      unique case (cpu_addr_i)
         FSP_ADDR_STATUS: rd_mux = {5'h00, protect_flag, verify_flag, 1'b0};
         FSP_ADDR_CMD: rd_mux = {5'h00, cur_ff.cmd};
         FSP_ADDR_PTR_LO: rd_mux = ptr_lo;
         FSP_ADDR_PTR_HI: rd_mux = ptr_hi;
         FSP_ADDR_CMP_HI: rd_mux = cmp_hi;
         FSP_ADDR_CMP_LO: rd_mux = cmp_lo;
         FSP_ADDR_WBUF: rd_mux = cur_ff.wbuf;
         default: rd_mux = 8'h00;
      endcase
   end

   always_comb begin
      nxt_state = cur_ff;
      nxt_state.rd = 1'b0;
      nxt_state.wr = 1'b0;
      nxt_state.erase = 1'b0;
      set_verify = 1'b0;
      set_protect = 1'b0;
      inc = 1'b0;
      if (cpu_rd_i) begin
         nxt_state.rdata = rd_mux;
      end
      // The write buffer is frozen while a command runs so the programmed byte is stable.
      if (cpu_wr_i && idle && cpu_addr_i == FSP_ADDR_WBUF) begin
         nxt_state.wbuf = cpu_wdata_i;
      end
      unique case (cur_ff.st)
         ST_IDLE: begin
            if (wr_cmd) begin
               nxt_state.cmd = cpu_wdata_i[2:0];
               if (!code_valid && cpu_wdata_i[2:0] != FSP_CMD_NONE) begin
                  set_protect = 1'b1;
               end else if (code_valid && mode_ok && block_protect_i) begin
                  set_protect = 1'b1;
               end else if (launch) begin
                  nxt_state.busy = 1'b1;
                  if (cpu_wdata_i[2:0] == FSP_CMD_ERASE) begin
                     nxt_state.st = ST_ERASE;
                     nxt_state.erase = 1'b1;
                  end else begin
                     nxt_state.st = ST_READ;
                     nxt_state.rd = 1'b1;
                  end
               end
            end
         end
         ST_READ: begin
            nxt_state.st = ST_CHECK;
         end
         ST_CHECK: begin
            if (cur_ff.cmd == FSP_CMD_BYTE_WRITE) begin
               if (one_over_zero) begin
                  set_protect = 1'b1;
                  nxt_state.st = ST_IDLE;
                  nxt_state.busy = 1'b0;
               end else begin
                  nxt_state.st = ST_PROG;
                  nxt_state.wr = 1'b1;
               end
            end else if (fail) begin
               set_verify = 1'b1;
               nxt_state.st = ST_IDLE;
               nxt_state.busy = 1'b0;
            end else if (last) begin
               nxt_state.st = ST_IDLE;
               nxt_state.busy = 1'b0;
            end else begin
               inc = 1'b1;
               nxt_state.st = ST_READ;
               nxt_state.rd = 1'b1;
            end
         end
         ST_PROG: begin
            nxt_state.st = ST_WAIT;
         end
         ST_ERASE: begin
            nxt_state.st = ST_WAIT;
         end
         ST_WAIT: begin
            if (fl_ack_i) begin
               set_verify = fl_fail_i;
               nxt_state.st = ST_IDLE;
               nxt_state.busy = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         cur_ff <= '{st: ST_IDLE, cmd: FSP_RST_CMD, wbuf: FSP_RST_BYTE, rdata: FSP_RST_BYTE, default: 1'b0};
      end else begin
         cur_ff <= nxt_state;
      end
   end

   // Pointer writes are ignored while busy; software reloads them between commands anyway.
   fsp_addr_ctr u_addr_ctr (
      .clk_i(core_clk_i),
      .rst_n_i(rst_n),
      .wdata_i(cpu_wdata_i),
      .wr_ptr_lo_i(cpu_wr_i && idle && cpu_addr_i == FSP_ADDR_PTR_LO),
      .wr_ptr_hi_i(cpu_wr_i && idle && cpu_addr_i == FSP_ADDR_PTR_HI),
      .wr_cmp_lo_i(cpu_wr_i && idle && cpu_addr_i == FSP_ADDR_CMP_LO),
      .wr_cmp_hi_i(cpu_wr_i && idle && cpu_addr_i == FSP_ADDR_CMP_HI),
      .inc_i(inc),
      .ptr_lo_o(ptr_lo),
      .ptr_hi_o(ptr_hi),
      .cmp_lo_o(cmp_lo),
      .cmp_hi_o(cmp_hi),
      .match_o(match)
   );

   fsp_err_flag u_verify_flag (
      .clk_i(core_clk_i),
      .rst_n_i(rst_n),
      .set_i(set_verify),
      .clr_i(wr_status && !cpu_wdata_i[FSP_VERIFY_BIT]),
      .flag_o(verify_flag)
   );

   fsp_err_flag u_protect_flag (
      .clk_i(core_clk_i),
      .rst_n_i(rst_n),
      .set_i(set_protect),
      .clr_i(wr_status && !cpu_wdata_i[FSP_PROTECT_BIT]),
      .flag_o(protect_flag)
   );

   assign cpu_rdata_o = cur_ff.rdata;
   assign seq_busy_o = cur_ff.busy;
   assign fl_addr_o = {ptr_hi[3:0], ptr_lo};
   assign fl_rd_o = cur_ff.rd;
   assign fl_wr_o = cur_ff.wr;
   assign fl_wdata_o = cur_ff.wbuf;
   assign fl_erase_o = cur_ff.erase;

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n);

   a_launch_sets_busy: assert property (launch |=> seq_busy_o)
      else $error("valid command did not start the sequencer");
   a_erase_one_pulse: assert property (launch && cpu_wdata_i[2:0] == FSP_CMD_ERASE
      |=> fl_erase_o ##1 !fl_erase_o)
      else $error("erase command did not give one erase pulse");
   a_blank_fail_flag: assert property (cur_ff.st == ST_CHECK && cur_ff.cmd == FSP_CMD_BLANK
      && fl_rdata_i != FSP_ERASED_BYTE |=> verify_flag && !seq_busy_o)
      else $error("non-erased byte not reported by blank check");
   a_write_buffer_out: assert property (cur_ff.st == ST_CHECK && cur_ff.cmd == FSP_CMD_BYTE_WRITE
      && !one_over_zero |=> fl_wr_o && fl_wdata_o == $past(cur_ff.wbuf) && fl_addr_o == $past(fl_addr_o))
      else $error("byte write did not program the buffer at the pointer");
   a_one_over_zero: assert property (cur_ff.st == ST_CHECK && cur_ff.cmd == FSP_CMD_BYTE_WRITE
      && one_over_zero |=> protect_flag && !fl_wr_o && !seq_busy_o)
      else $error("one over zero not reported");
   a_bad_code_flag: assert property (wr_cmd && idle && cpu_wdata_i[2:0] > FSP_CMD_BYTE_WRITE
      |=> protect_flag && !seq_busy_o)
      else $error("undefined command not ended with an error");
   a_pointer_steps: assert property (inc |=> fl_rd_o && fl_addr_o[7:0] == $past(fl_addr_o[7:0]) + 8'h01)
      else $error("pointer did not advance by one");
   a_stop_at_cmp: assert property (cur_ff.st == ST_CHECK && cur_ff.cmd == FSP_CMD_VERIFY_MULTI
      && !fail && match |=> !seq_busy_o ##1 !fl_rd_o)
      else $error("verify walk ran past the compare value");
   a_verify_fail_flag: assert property (cur_ff.st == ST_CHECK
      && (cur_ff.cmd == FSP_CMD_VERIFY_BLOCK || cur_ff.cmd == FSP_CMD_VERIFY_MULTI)
      && fl_rd_fail_i |=> verify_flag)
      else $error("verify failure not reported");
   a_ptr_load: assert property (cpu_wr_i && idle && cpu_addr_i == FSP_ADDR_PTR_LO
      |=> fl_addr_o[7:0] == $past(cpu_wdata_i))
      else $error("pointer low byte not loaded");
   // A program or erase that fails its own check must surface as a verify error, never as a silent finish.
   a_prog_fail_flag: assert property (cur_ff.st == ST_WAIT && fl_ack_i && fl_fail_i
      |=> verify_flag && !seq_busy_o)
      else $error("failed program or erase not reported");
   a_block_end: assert property (cur_ff.st == ST_CHECK && cur_ff.cmd == FSP_CMD_VERIFY_BLOCK
      && !fail && ptr_lo == FSP_LAST_OFFSET |=> !seq_busy_o && !fl_rd_o)
      else $error("whole-block verify ran past the last offset");

   c_erase_done: cover property (fl_erase_o ##[1:50] fl_ack_i);
   c_write_done: cover property (fl_wr_o ##[1:50] fl_ack_i && !fl_fail_i);
   c_walk_three: cover property (inc ##2 inc ##2 inc);
   c_blank_fail: cover property (cur_ff.st == ST_CHECK && cur_ff.cmd == FSP_CMD_BLANK && fail);
   c_verify2_done: cover property (cur_ff.st == ST_CHECK && cur_ff.cmd == FSP_CMD_VERIFY_MULTI && match && !fail);

endmodule

/* File: tb/tb.sv */
// Self-checking bench for the flash self-programming command and address sequencer.
module tb
   import fsp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic [7:0] rdata;
   } fsp_row_t;

   logic core_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [15:0] cpu_addr_i = 16'h0000;
   logic [7:0] cpu_wdata_i = 8'h00;
   logic cpu_wr_i = 1'b0;
   logic cpu_rd_i = 1'b0;
   logic [7:0] cpu_rdata_o;
   logic self_prog_mode_i = 1'b0;
   logic onboard_mode_i = 1'b0;
   logic block_protect_i = 1'b0;
   logic seq_busy_o;
   logic [11:0] fl_addr_o;
   logic fl_rd_o;
   logic [7:0] fl_rdata_i = 8'h00;
   logic fl_rd_fail_i = 1'b0;
   logic fl_wr_o;
   logic [7:0] fl_wdata_o;
   logic fl_erase_o;
   logic fl_ack_i = 1'b0;
   logic fl_fail_i = 1'b0;

   int fails = 0;
   int checked = 0;
   int cyc = 0;
   int rd_cnt = 0;
   int wr_cnt = 0;
   int er_cnt = 0;
   int ack_cnt = 0;
   logic [11:0] rd_addr = 12'h000;
   logic [11:0] wr_addr = 12'h000;
   logic [7:0] wr_data = 8'h00;
   logic [7:0] rd_val = 8'hFF;
   logic [11:0] fail_addr = 12'hFFF;
   logic prog_fail = 1'b0;
   logic b;

   fsp_row_t rows [7] = '{
      '{16'hFFA4, 8'h3C, 8'h3C}, '{16'hFFA5, 8'h05, 8'h05}, '{16'hFFA6, 8'h0A, 8'h0A},
      '{16'hFFA7, 8'hC3, 8'hC3}, '{16'hFFA8, 8'h96, 8'h96}, '{16'hFFA3, 8'h00, 8'h00},
      '{16'hFFA2, 8'h55, 8'h00}
   };

   fsp_seq_top i_dut (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .cpu_addr_i(cpu_addr_i),
      .cpu_wdata_i(cpu_wdata_i),
      .cpu_wr_i(cpu_wr_i),
      .cpu_rd_i(cpu_rd_i),
      .cpu_rdata_o(cpu_rdata_o),
      .self_prog_mode_i(self_prog_mode_i),
      .onboard_mode_i(onboard_mode_i),
      .block_protect_i(block_protect_i),
      .seq_busy_o(seq_busy_o),
      .fl_addr_o(fl_addr_o),
      .fl_rd_o(fl_rd_o),
      .fl_rdata_i(fl_rdata_i),
      .fl_rd_fail_i(fl_rd_fail_i),
      .fl_wr_o(fl_wr_o),
      .fl_wdata_o(fl_wdata_o),
      .fl_erase_o(fl_erase_o),
      .fl_ack_i(fl_ack_i),
      .fl_fail_i(fl_fail_i)
   );

   initial begin
      forever #2.5 core_clk_i = ~core_clk_i;
   end

   // The flash array answers reads one cycle later and toggles its read data and read-fail outputs otherwise, so stale data never passes.
   always @(posedge core_clk_i) begin
      if (fl_rd_o === 1'b1) begin
         rd_cnt <= rd_cnt + 1;
         rd_addr <= fl_addr_o;
      end
      fl_rdata_i <= (fl_rd_o === 1'b1) ? rd_val : ~fl_rdata_i;
      fl_rd_fail_i <= (fl_rd_o === 1'b1) ? (fl_addr_o === fail_addr) : ~fl_rd_fail_i;
      if (fl_wr_o === 1'b1) begin
         wr_cnt <= wr_cnt + 1;
         wr_data <= fl_wdata_o;
      end
      if (fl_erase_o === 1'b1) begin
         er_cnt <= er_cnt + 1;
      end
      if (fl_wr_o === 1'b1 || fl_erase_o === 1'b1) begin
         wr_addr <= fl_addr_o;
         ack_cnt <= 3;
      end else if (ack_cnt > 0) begin
         ack_cnt <= ack_cnt - 1;
      end
      fl_ack_i <= (ack_cnt == 1);
      fl_fail_i <= (ack_cnt == 1) && prog_fail;
   end

   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         $display("Error timeout expected completion seen hang");
         results();
      end
   end

   task automatic results();
      $display("Comparisons %0d, mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
      checked++;
      if (g !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      cpu_addr_i <= a;
      cpu_wdata_i <= d;
      cpu_wr_i <= 1'b1;
      @(posedge core_clk_i);
      cpu_wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] e, input string n);
      @(posedge core_clk_i);
      cpu_addr_i <= a;
      cpu_rd_i <= 1'b1;
      @(posedge core_clk_i);
      cpu_rd_i <= 1'b0;
      @(posedge core_clk_i);
      #1;
      chk(n, {4'h0, e}, {4'h0, cpu_rdata_o});
   endtask

   task automatic setup(input logic [7:0] ph, input logic [7:0] pl, input logic [7:0] ch, input logic [7:0] cl);
      wr(FSP_ADDR_PTR_HI, ph);
      wr(FSP_ADDR_PTR_LO, pl);
      wr(FSP_ADDR_CMP_HI, ch);
      wr(FSP_ADDR_CMP_LO, cl);
      rd_cnt = 0;
   endtask

   // Launches a command and waits a bounded time for the sequencer to go idle again.
   task automatic run(input logic [2:0] code, output logic busy);
      wr(FSP_ADDR_CMD, {5'h00, code});
      #1;
      busy = seq_busy_o;
      for (int i = 0; i < 2000 && seq_busy_o !== 1'b0; i++) begin
         @(posedge core_clk_i);
         #1;
      end
      chk("busy_end", 12'h000, {11'h000, seq_busy_o});
   endtask

   task automatic mode(input logic s, input logic o, input logic p);
      @(posedge core_clk_i);
      self_prog_mode_i <= s;
      onboard_mode_i <= o;
      block_protect_i <= p;
   endtask

   initial begin
      repeat (20) @(posedge core_clk_i);
      reset_n_i <= 1'b1;
      repeat (5) @(posedge core_clk_i);
      foreach (rows[i]) begin
         wr(rows[i].addr, rows[i].wdata);
         rd(rows[i].addr, rows[i].rdata, "reg_row");
      end
      @(posedge core_clk_i);
      reset_n_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      reset_n_i <= 1'b1;
      repeat (5) @(posedge core_clk_i);
      rd(FSP_ADDR_CMP_HI, 8'h00, "cmp_hi_reset");
      rd(FSP_ADDR_CMP_LO, 8'h00, "cmp_lo_reset");
      rd(FSP_ADDR_WBUF, 8'h00, "wbuf_reset");
      rd(FSP_ADDR_STATUS, 8'h00, "status_reset");
      mode(1'b1, 1'b0, 1'b0);
      // Blank check over the top sixteen offsets of block 1.
      rd_val = FSP_ERASED_BYTE;
      setup(8'h01, 8'hF0, 8'h01, 8'hFF);
      run(FSP_CMD_BLANK, b);
      chk("blank_busy", 12'h001, {11'h000, b});
      chk("blank_reads", 12'd16, 12'(rd_cnt));
      chk("blank_last", 12'h1FF, rd_addr);
      rd(FSP_ADDR_PTR_LO, 8'hFF, "ptr_counted");
      rd(FSP_ADDR_STATUS, 8'h00, "blank_ok");
      // A byte that is not erased stops the blank check at once.
      rd_val = 8'hEF;
      setup(8'h01, 8'h00, 8'h01, 8'hFF);
      run(FSP_CMD_BLANK, b);
      chk("blank_fail_reads", 12'd1, 12'(rd_cnt));
      rd(FSP_ADDR_STATUS, 8'h02, "blank_fail_flag");
      wr(FSP_ADDR_STATUS, 8'h00);
      rd(FSP_ADDR_STATUS, 8'h00, "flag_clear");
      // Multi-address verify fails at its fifth address.
      rd_val = 8'h5A;
      fail_addr = 12'h214;
      setup(8'h02, 8'h10, 8'h02, 8'h1F);
      run(FSP_CMD_VERIFY_MULTI, b);
      chk("verify2_start", 12'h210, 12'h214 - 12'(rd_cnt - 1));
      rd(FSP_ADDR_STATUS, 8'h02, "verify2_flag");
      wr(FSP_ADDR_STATUS, 8'h00);
      fail_addr = 12'hFFF;
      // A clean multi-address verify must stop exactly at the compare value.
      setup(8'h02, 8'h18, 8'h02, 8'h1B);
      run(FSP_CMD_VERIFY_MULTI, b);
      chk("verify2_reads", 12'h004, 12'(rd_cnt));
      chk("verify2_last", 12'h21B, rd_addr);
      setup(8'h03, 8'hF8, 8'h03, 8'hFF);
      run(FSP_CMD_VERIFY_BLOCK, b);
      chk("verify1_reads", 12'd8, 12'(rd_cnt));
      chk("verify1_last", 12'h3FF, rd_addr);
      rd(FSP_ADDR_STATUS, 8'h00, "verify1_ok");
      // Erase from on-board mode alone, with a failing erase verification.
      mode(1'b0, 1'b1, 1'b0);
      prog_fail = 1'b1;
      setup(8'h05, 8'h00, 8'h05, 8'h00);
      run(FSP_CMD_ERASE, b);
      chk("erase_busy", 12'h001, {11'h000, b});
      chk("erase_count", 12'd1, 12'(er_cnt));
      chk("erase_block", 12'h500, wr_addr);
      rd(FSP_ADDR_STATUS, 8'h02, "erase_fail_flag");
      wr(FSP_ADDR_STATUS, 8'h00);
      // On-board mode accepts no other command.
      run(FSP_CMD_VERIFY_MULTI, b);
      chk("onboard_verify", 12'h000, 12'(rd_cnt));
      prog_fail = 1'b0;
      mode(1'b1, 1'b0, 1'b0);
      // Byte write onto an erased byte.
      rd_val = FSP_ERASED_BYTE;
      setup(8'h06, 8'h22, 8'h06, 8'h22);
      wr(FSP_ADDR_WBUF, 8'h5A);
      run(FSP_CMD_BYTE_WRITE, b);
      chk("write_count", 12'd1, 12'(wr_cnt));
      chk("write_addr", 12'h622, wr_addr);
      chk("write_data", 12'h05A, {4'h0, wr_data});
      rd(FSP_ADDR_STATUS, 8'h00, "write_ok");
      // Programming ones over zeros is refused and flagged.
      rd_val = 8'h0F;
      setup(8'h06, 8'h23, 8'h06, 8'h23);
      wr(FSP_ADDR_WBUF, 8'hF0);
      run(FSP_CMD_BYTE_WRITE, b);
      chk("overwrite_count", 12'd1, 12'(wr_cnt));
      rd(FSP_ADDR_STATUS, 8'h04, "overwrite_flag");
      wr(FSP_ADDR_STATUS, 8'h00);
      for (int c = 6; c < 8; c++) begin
         setup(8'h01, 8'h00, 8'h01, 8'hFF);
         run(3'(c), b);
         chk("undef_busy", 12'h000, {11'h000, b});
         rd(FSP_ADDR_STATUS, 8'h04, "undef_flag");
         wr(FSP_ADDR_STATUS, 8'h00);
      end
      // A protected block refuses a valid command.
      mode(1'b1, 1'b0, 1'b1);
      setup(8'h01, 8'h00, 8'h01, 8'hFF);
      run(FSP_CMD_BLANK, b);
      chk("protect_reads", 12'h000, 12'(rd_cnt));
      rd(FSP_ADDR_STATUS, 8'h04, "protect_flag");
      results();
   end
endmodule
